/* File: rtl/cbh_cfg.svh */
/*
 Constants of the card bridge configuration header slice: offsets, field
 positions, fixed read values and reset values.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef CBH_CFG_SVH
`define CBH_CFG_SVH

// ----------------------------------------------------------------
// Byte offsets inside configuration space
// ----------------------------------------------------------------
`define CBH_OFF_CLS 8'h0C
`define CBH_OFF_LAT 8'h0D
`define CBH_OFF_HDR 8'h0E
`define CBH_OFF_SELF_TEST_CONTROL 8'h0F
`define CBH_OFF_BAR 8'h10
`define CBH_OFF_CAP 8'h14
`define CBH_OFF_SEC 8'h16
`define CBH_OFF_PM_ID 8'hA0
`define CBH_OFF_PM_CSR 8'hA4
`define CBH_EXT_FIRST 8'h80

// ----------------------------------------------------------------
// Fixed read values and reset values
// ----------------------------------------------------------------
`define CBH_CLS_RESET 8'h00
`define CBH_LAT_RESET 8'h00
`define CBH_HDR_VALUE 8'h82
`define CBH_SELF_TEST_CONTROL_VALUE 8'h00
`define CBH_BAR_RESET 20'h00000
`define CBH_BAR_LOW_ZERO 12'h000
`define CBH_CAP_VALUE 8'hA0
`define CBH_SEC_RESET 16'h0200
`define CBH_SEC_TIMING 2'h1
`define CBH_PM_CAP_ID 8'h01
`define CBH_PM_NEXT 8'h00
`define CBH_PM_CAPS 16'h0002
`define CBH_PM_STATE_RESET 2'h0

// ----------------------------------------------------------------
// Window decode: legacy register set starts at offset 800h
// ----------------------------------------------------------------
`define CBH_WIN_LEGACY_BIT 11

`endif

/* File: rtl/cbh_pkg.sv */
/*
 Types shared by the card bridge configuration header slice.
 Assumes cbh_cfg.svh is on the include path.
*/
`include "cbh_cfg.svh"

package cbh_pkg;

   // Latency timer sequencing for the initiator side
   typedef enum logic [1:0] {CBH_LT_IDLE, CBH_LT_RUN, CBH_LT_EXPIRED} cbh_lt_state_e;

   // Clearable card side flags, packed as {b15,b14,b13,b12,b11,b8}
   typedef logic [5:0] cbh_flags_t;

endpackage

/* File: rtl/cbh_config_header.sv */
/*
 Card bridge configuration header slice for two socket functions: cache
 line size, latency timer and its initiator expiry, header type, self test,
 socket window base with its 4 KB decode, capability pointer, power
 management block and the card side status register.
 Assumes configuration and memory requests arrive synchronous to ref_clk,
 one per cycle at most, and that event inputs are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cbh_cfg.svh"

// Summary of operation
// - Cache line size: 8-bit RW, resets zero
// - Latency timer RW; restarts at frame start
// - Expired timer ends transfer once grant drops
// - Header type always reads 82h
// - 00h-7Fh standard header, 80h-FFh extension
// - Self test register reads zero
// - Base bits 31-12 writable, 11-0 zero
// - All-ones write reads back FFFFF000h
// - Window: socket regs 000h, legacy 800h
// - Each function keeps its own base
// - Capability pointer reads A0h per function
// - Power management block at A0h, A4h
// - Writing one clears flag, zero keeps
// - Per-function status, reset 0200h, clearable bits
// - Card parity error sets bit 15
// - Abort events set bits 13, 12, 11
// - Select timing field fixed medium
module cbh_config_header
   import cbh_pkg::*;
#(
   parameter int NUM_FUNC = 2
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cfg_req,
   input wire logic cfg_write,
   input wire logic cfg_func,
   input wire logic [5:0] cfg_dword,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   input wire logic init_frame_start,
   input wire logic init_func,
   input wire logic init_active,
   input wire logic gnt_n,
   output logic init_stop,
   output logic lat_expired,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [NUM_FUNC-1:0] mem_space_en,
   output logic mem_hit,
   output logic mem_func,
   output logic mem_legacy,
   output logic [10:0] mem_offset,
   input wire logic [NUM_FUNC-1:0] card_parity_detected,
   input wire logic [NUM_FUNC-1:0] card_serr_seen,
   input wire logic [NUM_FUNC-1:0] card_master_abort_received,
   input wire logic [NUM_FUNC-1:0] card_target_abort_received,
   input wire logic [NUM_FUNC-1:0] card_target_abort_signaled,
   input wire logic [NUM_FUNC-1:0] card_data_parity
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] cls_ff [NUM_FUNC];
   logic [7:0] lat_ff [NUM_FUNC];
   logic [19:0] bar_ff [NUM_FUNC];
   cbh_flags_t flags_ff [NUM_FUNC];
   logic [1:0] pm_state_ff [NUM_FUNC];
   logic cfg_ack_ff;
   logic [31:0] cfg_rdata_ff;
   logic [31:0] nxt_rdata;
   cbh_lt_state_e lt_state_ff;
   cbh_lt_state_e nxt_lt_state;
   logic [7:0] lat_cnt_ff;
   logic lt_func_ff;
   logic init_stop_ff;
   logic lat_expired_ff;
   logic mem_hit_ff;
   logic mem_func_ff;
   logic mem_legacy_ff;
   logic [10:0] mem_offset_ff;

   // ----------------------------------------------------------------
   // Configuration address decode
   // ----------------------------------------------------------------
   // Byte address of the selected doubleword and its per-register hits
   wire [7:0] cfg_off = {cfg_dword, 2'b00};
   wire wr = cfg_req && cfg_write;
   wire rd_sel_misc = (cfg_off == `CBH_OFF_CLS);
   wire sel_bar = (cfg_off == `CBH_OFF_BAR);
   wire sel_cap = (cfg_off == `CBH_OFF_CAP);
   wire sel_pm_id = (cfg_off == `CBH_OFF_PM_ID);
   wire sel_pm_csr = (cfg_off == `CBH_OFF_PM_CSR);
   wire in_ext = (cfg_off >= `CBH_EXT_FIRST);
   // Status word sits in the upper half of the capability doubleword
   wire wr_sec = wr && sel_cap && cfg_be[3];

   // Read value of the card side status of the addressed function
   function automatic logic [15:0] sec_word(input cbh_flags_t f);
      sec_word = {f[5:1], `CBH_SEC_TIMING, f[0], 8'h00};
   endfunction

   // Read multiplexer, decoded on the byte offset
   always_comb begin
      nxt_rdata = 32'h00000000;
      if (rd_sel_misc) begin
         nxt_rdata = {`CBH_SELF_TEST_CONTROL_VALUE, `CBH_HDR_VALUE, lat_ff[cfg_func],
                      cls_ff[cfg_func]};
      end else if (sel_bar) begin
         nxt_rdata = {bar_ff[cfg_func], `CBH_BAR_LOW_ZERO};
      end else if (sel_cap) begin
         nxt_rdata = {sec_word(flags_ff[cfg_func]), 8'h00, `CBH_CAP_VALUE};
      end else if (sel_pm_id) begin
         nxt_rdata = {`CBH_PM_CAPS, `CBH_PM_NEXT, `CBH_PM_CAP_ID};
      end else if (sel_pm_csr) begin
         nxt_rdata = {30'h00000000, pm_state_ff[cfg_func]};
      end else if (in_ext) begin
         nxt_rdata = 32'h00000000;
      end
   end

   // Answer one cycle after each request, writes included
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_ack_ff <= 1'b0;
         cfg_rdata_ff <= 32'h00000000;
      end else begin
         cfg_ack_ff <= cfg_req;
         cfg_rdata_ff <= (cfg_req && !cfg_write) ? nxt_rdata : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Per-function writable registers
   // ----------------------------------------------------------------
   // Header type, self test and pointers have no storage, so writes vanish
   genvar g;
   generate
      for (g = 0; g < NUM_FUNC; g++) begin : g_func
         wire hit = wr && (cfg_func == 1'(g));
         wire cbh_flags_t set_v = {card_parity_detected[g], card_serr_seen[g],
                                   card_master_abort_received[g],
                                   card_target_abort_received[g],
                                   card_target_abort_signaled[g],
                                   card_data_parity[g]};
         wire cbh_flags_t clr_v = (hit && wr_sec) ?
                                  {cfg_wdata[31:27], cfg_wdata[24]} : 6'h00;

         // Cache line size, latency value, base and power state
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               cls_ff[g] <= `CBH_CLS_RESET;
               lat_ff[g] <= `CBH_LAT_RESET;
               bar_ff[g] <= `CBH_BAR_RESET;
               pm_state_ff[g] <= `CBH_PM_STATE_RESET;
            end else if (hit) begin
               if (rd_sel_misc && cfg_be[0]) cls_ff[g] <= cfg_wdata[7:0];
               if (rd_sel_misc && cfg_be[1]) lat_ff[g] <= cfg_wdata[15:8];
               if (sel_bar && cfg_be[3]) bar_ff[g][19:12] <= cfg_wdata[31:24];
               if (sel_bar && cfg_be[2]) bar_ff[g][11:4] <= cfg_wdata[23:16];
               if (sel_bar && cfg_be[1]) bar_ff[g][3:0] <= cfg_wdata[15:12];
               if (sel_pm_csr && cfg_be[0]) pm_state_ff[g] <= cfg_wdata[1:0];
            end
         end

         // Sticky flags: a new event wins over a clear in the same cycle
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               flags_ff[g] <= cbh_flags_t'(6'h00);
            end else begin
               flags_ff[g] <= (flags_ff[g] & ~clr_v) | set_v;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Latency timer
   // ----------------------------------------------------------------
   wire [7:0] lat_limit = lat_ff[lt_func_ff];
   wire lat_reached = (lat_cnt_ff >= lat_limit);

   // Sequencing of one initiator transaction
   always_comb begin
      nxt_lt_state = lt_state_ff;
      case (lt_state_ff)
         CBH_LT_IDLE: begin
            if (init_frame_start) nxt_lt_state = CBH_LT_RUN;
         end
         CBH_LT_RUN: begin
            if (init_frame_start) nxt_lt_state = CBH_LT_RUN;
            else if (!init_active) nxt_lt_state = CBH_LT_IDLE;
            else if (lat_reached) nxt_lt_state = CBH_LT_EXPIRED;
         end
         CBH_LT_EXPIRED: begin
            if (init_frame_start) nxt_lt_state = CBH_LT_RUN;
            else if (!init_active) nxt_lt_state = CBH_LT_IDLE;
         end
         default: nxt_lt_state = CBH_LT_IDLE;
      endcase
   end

   // Counter restarts from zero on every frame start
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lt_state_ff <= CBH_LT_IDLE;
         lat_cnt_ff <= 8'h00;
         lt_func_ff <= 1'b0;
      end else begin
         lt_state_ff <= nxt_lt_state;
         if (init_frame_start) begin
            lat_cnt_ff <= 8'h00;
            lt_func_ff <= init_func;
         end else if (lt_state_ff == CBH_LT_RUN && !lat_reached) begin
            lat_cnt_ff <= lat_cnt_ff + 8'h01;
         end
      end
   end

   // Stop request once expired and grant has been taken away
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         init_stop_ff <= 1'b0;
         lat_expired_ff <= 1'b0;
      end else begin
         init_stop_ff <= (lt_state_ff == CBH_LT_EXPIRED) && init_active && gnt_n
                         && !init_frame_start;
         lat_expired_ff <= (nxt_lt_state == CBH_LT_EXPIRED);
      end
   end

   // ----------------------------------------------------------------
   // Socket window decode
   // ----------------------------------------------------------------
   wire hit0 = mem_space_en[0] && (mem_addr[31:12] == bar_ff[0]);
   wire hit1 = mem_space_en[1] && (mem_addr[31:12] == bar_ff[1]);

   // Function 0 has priority should both windows overlap
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mem_hit_ff <= 1'b0;
         mem_func_ff <= 1'b0;
         mem_legacy_ff <= 1'b0;
         mem_offset_ff <= 11'h000;
      end else begin
         mem_hit_ff <= mem_req && (hit0 || hit1);
         mem_func_ff <= mem_req && !hit0 && hit1;
         mem_legacy_ff <= mem_req && mem_addr[`CBH_WIN_LEGACY_BIT];
         mem_offset_ff <= mem_req ? mem_addr[10:0] : 11'h000;
      end
   end

   // Ports straight from flip-flops
   assign cfg_ack = cfg_ack_ff;
   assign cfg_rdata = cfg_rdata_ff;
   assign init_stop = init_stop_ff;
   assign lat_expired = lat_expired_ff;
   assign mem_hit = mem_hit_ff;
   assign mem_func = mem_func_ff;
   assign mem_legacy = mem_legacy_ff;
   assign mem_offset = mem_offset_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_rd(logic [7:0] off);
      cfg_req && !cfg_write && (cfg_off == off);
   endsequence

   sequence s_bar_ones(logic f);
      cfg_req && cfg_write && sel_bar && (cfg_be == 4'hF) && (cfg_wdata == 32'hFFFFFFFF)
      && (cfg_func == f);
   endsequence

   sequence s_rd_bar(logic f);
      cfg_req && !cfg_write && sel_bar && (cfg_func == f);
   endsequence

   a_hdr_self_test_control_const: assert property (s_rd(`CBH_OFF_CLS) |=>
      cfg_ack_ff && (cfg_rdata_ff[31:16] == 16'h0082))
      else $error("header type or self test value wrong");

   a_cls_write: assert property (wr && rd_sel_misc && cfg_be[0] && !cfg_func
      |=> cls_ff[0] == $past(cfg_wdata[7:0]))
      else $error("cache line size not stored");

   a_lat_restart: assert property (init_frame_start |=>
      lat_cnt_ff == 8'h00 && lt_state_ff == CBH_LT_RUN)
      else $error("latency timer did not restart");

   a_lat_stop: assert property ((lt_state_ff == CBH_LT_EXPIRED) && init_active && gnt_n
      && !init_frame_start |=> init_stop_ff)
      else $error("expired transfer not stopped after grant loss");

   a_stop_cause: assert property (init_stop_ff |->
      $past(lt_state_ff) == CBH_LT_EXPIRED && $past(gnt_n))
      else $error("stop without expiry and grant loss");

   a_bar_low_zero: assert property (s_rd(`CBH_OFF_BAR) |=>
      cfg_rdata_ff[11:0] == 12'h000)
      else $error("base low bits not zero");

   a_bar_all_ones: assert property (s_bar_ones(1'b0) ##1 !cfg_req ##1 s_rd_bar(1'b0)
      |=> cfg_rdata_ff == 32'hFFFFF000)
      else $error("all-ones base read back wrong");

   a_cap_timing: assert property (s_rd(`CBH_OFF_CAP) |=>
      cfg_rdata_ff[7:0] == 8'hA0 && cfg_rdata_ff[26:25] == 2'h1)
      else $error("capability pointer or timing field wrong");

   a_flag_set_wins: assert property (card_parity_detected[0] |=> flags_ff[0][5])
      else $error("parity event lost");

   a_flag_clear: assert property (wr_sec && !cfg_func && cfg_wdata[29]
      && !card_master_abort_received[0] |=> !flags_ff[0][3])
      else $error("master abort flag not cleared");

   a_flag_keep: assert property (wr_sec && !cfg_func && !cfg_wdata[31]
      && flags_ff[0][5] |=> flags_ff[0][5])
      else $error("flag cleared by zero write");

   a_window_legacy: assert property (mem_req && hit0 && mem_addr[11]
      |=> mem_hit_ff && mem_legacy_ff && !mem_func_ff)
      else $error("legacy window decode wrong");

   a_cfg_answer: assert property (cfg_req |=> cfg_ack_ff)
      else $error("configuration request not answered");

   a_ext_zero: assert property (cfg_req && !cfg_write && in_ext
      && !sel_pm_id && !sel_pm_csr |=> cfg_rdata_ff == 32'h00000000)
      else $error("extension read not zero");

   a_lat_expiry: assert property ((lt_state_ff == CBH_LT_RUN) && lat_reached
      && init_active && !init_frame_start |=> lat_expired_ff)
      else $error("latency expiry not flagged");

endmodule
`default_nettype wire

/* File: dv/cbh_host_model.sv */
/*
 Host side model: issues configuration and memory cycles to the header.
 Assumes the header answers each configuration request one cycle later.
*/
`timescale 1ns/1ns
`default_nettype none
module cbh_host_model (
   input wire logic ref_clk,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata,
   output logic cfg_req,
   output logic cfg_write,
   output logic cfg_func,
   output logic [5:0] cfg_dword,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   output logic mem_req,
   output logic [31:0] mem_addr
);
   // Idle values at time zero
   initial begin
      {cfg_req, cfg_write, cfg_func, cfg_dword, cfg_be, cfg_wdata} = '0;
      {mem_req, mem_addr} = '0;
   end
   // One config cycle; ones in a status write clear flags
   task automatic cfg(input logic f, w, input logic [5:0] d,
                      input logic [3:0] be, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ack);
      @(negedge ref_clk);
      {cfg_req, cfg_write, cfg_func, cfg_dword, cfg_be, cfg_wdata} = {1'b1, w, f, d, be, wd};
      @(negedge ref_clk);
      ack = cfg_ack;
      rd = cfg_rdata;
      cfg_req = 1'b0;
      cfg_wdata = ~wd; // Released data no longer valid
   endtask
   // One memory address phase
   task automatic mem(input logic [31:0] a);
      @(negedge ref_clk);
      mem_req = 1'b1;
      mem_addr = a;
      @(negedge ref_clk);
      mem_req = 1'b0;
      mem_addr = ~a;
   endtask
endmodule
`default_nettype wire

/* File: dv/test_cbh_config_header.sv */
/*
 Self-checking bench for the card bridge configuration header.
 Assumes the host model and design are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_cbh_config_header;
   import cbh_pkg::*;
   logic ref_clk, rst, cfg_req, cfg_write, cfg_func, cfg_ack, mem_req;
   logic [5:0] cfg_dword;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, mem_addr, seed, b0, b1, rd;
   logic init_frame_start, init_func, init_active, gnt_n, init_stop, lat_expired;
   logic [1:0] mem_space_en, card_parity_detected, card_serr_seen, card_data_parity;
   logic [1:0] card_master_abort_received, card_target_abort_received;
   logic [1:0] card_target_abort_signaled;
   logic mem_hit, mem_func, mem_legacy, ack;
   logic [10:0] mem_offset;
   logic [7:0] cl, lt;
   int failures, n_compared, k;
   cbh_config_header cbh_config_header_i (.ref_clk, .rst, .cfg_req, .cfg_write,
      .cfg_func, .cfg_dword, .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata,
      .init_frame_start, .init_func, .init_active, .gnt_n, .init_stop, .lat_expired,
      .mem_req, .mem_addr, .mem_space_en, .mem_hit, .mem_func, .mem_legacy, .mem_offset,
      .card_parity_detected, .card_serr_seen, .card_master_abort_received,
      .card_target_abort_received, .card_target_abort_signaled, .card_data_parity);
   cbh_host_model cbh_host_model_i (.ref_clk, .cfg_ack, .cfg_rdata, .cfg_req,
      .cfg_write, .cfg_func, .cfg_dword, .cfg_be, .cfg_wdata, .mem_req, .mem_addr);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [31:0] exp_bar(input logic [31:0] w);
      return {w[31:12], 12'h000};
   endfunction
   task automatic chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic f, input logic [5:0] d, input logic [31:0] e);
      cbh_host_model_i.cfg(f, 1'b0, d, 4'h0, 32'h0, rd, ack);
      chk({31'h0, ack}, 32'h1);
      chk(rd, e);
   endtask
   task automatic wr(input logic f, input logic [5:0] d, input logic [3:0] be,
                     input logic [31:0] w);
      cbh_host_model_i.cfg(f, 1'b1, d, be, w, rd, ack);
      chk({31'h0, ack}, 32'h1);
      chk(rd, 32'h0);
   endtask
   task automatic mchk(input logic [31:0] a, input logic h, f, l);
      cbh_host_model_i.mem(a);
      chk({mem_hit, mem_func, mem_legacy, mem_offset}, {h, f, l, a[10:0]});
   endtask
   task automatic summarize;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Clock of 4 ns period
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Watchdog against hangs
   initial begin
      #100000;
      failures++;
      summarize();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {init_frame_start, init_func, init_active, card_serr_seen} = '0;
      {card_parity_detected, card_master_abort_received, card_data_parity} = '0;
      {card_target_abort_received, card_target_abort_signaled} = '0;
      gnt_n = 1'b0;
      mem_space_en = 2'h3;
      failures = 0;
      n_compared = 0;
      seed = 32'h5EBCFE54;
      rst = 1'b1;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      // Reset and fixed values of both functions
      for (int f = 0; f < 2; f++) begin
         rdc(f[0], 6'h03, 32'h0082_0000);
         rdc(f[0], 6'h04, 32'h0000_0000);
         rdc(f[0], 6'h05, 32'h0200_00A0);
         rdc(f[0], 6'h28, 32'h0002_0001);
         rdc(f[0], 6'h29, 32'h0000_0000);
         rdc(f[0], 6'h20, 32'h0000_0000);
      end
      // Random cache line and latency, read-only lanes kept
      repeat (6) begin
         seed = xs(seed);
         wr(seed[0], 6'h03, 4'hF, seed);
         rdc(seed[0], 6'h03, {16'h0082, seed[15:8], seed[7:0]});
      end
      // Window base: all ones, then random for function 0, bit 20 flipped for function 1
      wr(1'b0, 6'h04, 4'hF, 32'hFFFF_FFFF);
      rdc(1'b0, 6'h04, 32'hFFFF_F000);
      seed = xs(seed);
      b0 = exp_bar(seed);
      b1 = b0 ^ 32'h0010_0000;
      wr(1'b0, 6'h04, 4'hF, seed);
      wr(1'b1, 6'h04, 4'hF, b1 | 32'h0000_0ABC);
      rdc(1'b0, 6'h04, b0);
      rdc(1'b1, 6'h04, b1);
      mchk(b0 + 32'h800, 1'b1, 1'b0, 1'b1);
      mchk(b0 + 32'h7FF, 1'b1, 1'b0, 1'b0);
      mchk(b1 + 32'hFFF, 1'b1, 1'b1, 1'b1);
      mchk(b0 ^ 32'h0020_0000, 1'b0, 1'b0, 1'b0);
      // Memory decode of function 0 switched off
      mem_space_en = 2'h2;
      mchk(b0 + 32'h10, 1'b0, 1'b0, 1'b0);
      mem_space_en = 2'h3;
      // Card side events set flags per function
      @(negedge ref_clk);
      {card_parity_detected[0], card_master_abort_received[0]} = 2'b11;
      card_target_abort_signaled[0] = 1'b1;
      {card_parity_detected[1], card_serr_seen[1], card_data_parity[1]} = 3'b111;
      {card_master_abort_received[1], card_target_abort_received[1]} = 2'b11;
      card_target_abort_signaled[1] = 1'b1;
      @(negedge ref_clk);
      {card_parity_detected, card_master_abort_received, card_data_parity} = '0;
      {card_target_abort_received, card_target_abort_signaled, card_serr_seen} = '0;
      rdc(1'b0, 6'h05, 32'hAA00_00A0);
      rdc(1'b1, 6'h05, 32'hFB00_00A0);
      wr(1'b1, 6'h05, 4'hC, 32'h8801_0000);
      rdc(1'b1, 6'h05, 32'h7300_00A0);
      wr(1'b0, 6'h05, 4'hF, 32'h0000_FFFF);
      rdc(1'b0, 6'h05, 32'hAA00_00A0);
      wr(1'b0, 6'h05, 4'h8, 32'h2000_0000);
      rdc(1'b0, 6'h05, 32'h8A00_00A0);
      // Latency expiry, then stop once grant drops
      seed = xs(seed);
      lt = {5'h0, seed[2:0]} + 8'h1;
      wr(seed[3], 6'h03, 4'h2, {16'h0, lt, 8'h0});
      @(negedge ref_clk);
      init_func = seed[3];
      {init_frame_start, init_active, gnt_n} = 3'b110;
      @(negedge ref_clk);
      init_frame_start = 1'b0;
      k = 0;
      while (lat_expired !== 1'b1 && k < 20) begin
         @(negedge ref_clk);
         k++;
      end
      chk(k, lt + 8'h1);
      @(negedge ref_clk);
      chk({31'h0, init_stop}, 32'h0);
      gnt_n = 1'b1;
      @(negedge ref_clk);
      chk({31'h0, init_stop}, 32'h1);
      init_active = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk({30'h0, init_stop, lat_expired}, 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
